// >>> hw/pmt_div_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pmt_div_if;
    logic       run;
    logic [2:0] shift;
    logic       tick;
    modport ctl (output run, output shift, input tick);
    modport div (input run, input shift, output tick);
endinterface
`default_nettype wire

// >>> hw/pmt_divider.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// clock divider tick generator
// ----------------------------------------
module pmt_divider
    import pmt_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    pmt_div_if.div    dif
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             tick_q;
    logic             tick_d;
    logic [CNT_W-1:0] last;

    if (CNT_W < 8)
    begin
        $error("pmt_divider: CNT_W too small");
    end

    // divide by 2**shift * 4 -> /4 .. /128
    always_comb
    begin
        last   = CNT_W'((32'd4 << dif.shift) - 32'd1);
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (dif.run)
        begin
            if (cnt_q >= last)
            begin
                cnt_d  = '0;
                tick_d = 1'b1;
            end
            else
                cnt_d = cnt_q + CNT_W'(1);
        end
        else
            cnt_d = '0;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign dif.tick = tick_q;
endmodule
`default_nettype wire

// >>> hw/pmt_pkg.sv
package pmt_pkg;
    // register byte addresses
    localparam logic [7:0] PMT_OFS_SSC   = 8'h00;
    localparam logic [7:0] PMT_OFS_TSC   = 8'h04;
    localparam logic [7:0] PMT_OFS_MODE  = 8'h08;
    localparam logic [7:0] PMT_OFS_WAIT  = 8'h0c;

    // standby_and_speed_control fields
    localparam int PMT_STBY_SEL_BIT = 7;
    localparam int PMT_STS_LSB      = 4;
    localparam int PMT_LOW_SPD_BIT  = 3;
    localparam int PMT_MA_LSB   = 0;
    localparam logic [7:0] PMT_SSC_RST  = 8'h07;
    localparam logic [7:0] PMT_SSC_WMSK = 8'hfb;

    // transfer_and_subclock_control fields
    localparam int PMT_NOISE_SEL_BIT = 4;
    localparam int PMT_DIRECT_BIT    = 3;
    localparam int PMT_MED_SPD_BIT   = 2;
    localparam int PMT_SA_LSB    = 0;
    localparam logic [7:0] PMT_TSC_RST  = 8'he0;
    localparam logic [7:0] PMT_TSC_WMSK = 8'h1f;

    // wait counts in states (clock cycles) and clock divider ratios
    localparam int PMT_WAIT_BASE_LOG2 = 13;
    localparam int PMT_WAIT_MAX_LOG2  = 17;
    localparam int PMT_NOISE_DIV_SLOW = 16;
    localparam int PMT_NOISE_DIV_FAST = 4;
    localparam int PMT_MED_DIV_BASE   = 16;

    typedef enum logic [2:0]
    {
        PMT_ACT_HIGH,
        PMT_ACT_MED,
        PMT_SUBACT,
        PMT_SLEEP,
        PMT_SUBSLEEP,
        PMT_STANDBY,
        PMT_WATCH
    } pmt_mode_t;
endpackage

// >>> hw/pmt_top.sv
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// Contract
// [R1] SLEEP in active mode, standby clear: enter sleep mode.
// [R2] SLEEP in subactive mode, standby clear: enter subsleep mode.
// [R3] SLEEP in active mode, standby set: enter standby or watch mode.
// [R4] SLEEP in subactive mode, standby set: enter watch mode.
// [R5] Direct transfer off: SLEEP only enters power-down modes.
// [R6] Direct, high-speed, standby0 medium1 low0: go to medium-speed.
// [R7] Direct, active, standby1 timer-watch1 low1: go to subactive.
// [R8] Direct, medium-speed, standby0 medium0 low0: go to high-speed.
// [R9] Direct, subactive, standby1 watch1 low0 medium0: go to high-speed.
// [R10] Direct, subactive, standby1 watch1 low0 medium1: go to medium.
// [R11] Noise sample select: 0 gives osc/16, 1 gives osc/4.
// [R12] Standby wait: 8192,16384,32768,65536 states; top bit set 131072.
// [R13] Medium divider: osc/16,/32,/64,/128 for codes 00 to 11.
module pmt_top
    import pmt_pkg::*;
#(
    parameter int WAIT_W = 18
)
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        sleep_exec_i,
    input  wire logic        timer_watch_enable_bit_i,
    input  wire logic        wake_i,
    output logic [2:0]       mode_o,
    output logic             cpu_stopped_o,
    output logic             cpu_on_subclock_o,
    output logic             cpu_clk_en_o,
    output logic             noise_sample_o,
    output logic [1:0]       subactive_clock_divider_o
);
    if (WAIT_W < PMT_WAIT_MAX_LOG2 + 1)
    begin
        $error("pmt_top: WAIT_W too small");
    end

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    logic [7:0]  ssc_q;
    logic [7:0]  ssc_d;
    logic [7:0]  tsc_q;
    logic [7:0]  tsc_d;
    logic [31:0] prdata_d;
    logic        pready_d;
    logic        pslverr_d;
    logic        acc;
    pmt_mode_t   mode_q;
    pmt_mode_t   mode_d;
    logic [WAIT_W-1:0] wait_q;
    logic [WAIT_W-1:0] wait_d;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == PMT_OFS_SSC) || (a == PMT_OFS_TSC)
                || (a == PMT_OFS_MODE) || (a == PMT_OFS_WAIT);
    endfunction

    assign acc = psel_i && penable_i && !pready_o;

    always_comb
    begin
        ssc_d     = ssc_q;
        tsc_d     = tsc_q;
        prdata_d  = prdata_o;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (acc)
        begin
            pready_d  = 1'b1;
            pslverr_d = !addr_hit(paddr_i);
            prdata_d  = '0;
            if (pwrite_i)
            begin
                if (paddr_i == PMT_OFS_SSC)
                    ssc_d = (pwdata_i[7:0] & PMT_SSC_WMSK)
                          | (PMT_SSC_RST & ~PMT_SSC_WMSK);
                if (paddr_i == PMT_OFS_TSC)
                    tsc_d = (pwdata_i[7:0] & PMT_TSC_WMSK)
                          | (PMT_TSC_RST & ~PMT_TSC_WMSK);
            end
            else
            begin
                case (paddr_i)
                    PMT_OFS_SSC:  prdata_d = {24'h00_0000, ssc_q};
                    PMT_OFS_TSC:  prdata_d = {24'h00_0000, tsc_q};
                    PMT_OFS_MODE: prdata_d = {29'h0000_0000, mode_q};
                    PMT_OFS_WAIT: prdata_d = 32'(wait_q);
                    default:      prdata_d = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ssc_q     <= PMT_SSC_RST;
            tsc_q     <= PMT_TSC_RST;
            prdata_o  <= '0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else if (ce_i)
        begin
            ssc_q     <= ssc_d;
            tsc_q     <= tsc_d;
            prdata_o  <= prdata_d;
            pready_o  <= pready_d;
            pslverr_o <= pslverr_d;
        end
    end

    // ----------------------------------------
    // mode transitions
    // ----------------------------------------
    logic       stby_sel;
    logic       low_spd;
    logic       direct_en;
    logic       med_spd;
    logic       tw;
    logic [2:0] sts;
    logic [WAIT_W-1:0] wait_len;

    assign stby_sel  = ssc_q[PMT_STBY_SEL_BIT];
    assign low_spd   = ssc_q[PMT_LOW_SPD_BIT];
    assign sts       = ssc_q[PMT_STS_LSB +: 3];
    assign direct_en = tsc_q[PMT_DIRECT_BIT];
    assign med_spd   = tsc_q[PMT_MED_SPD_BIT];
    assign tw   = timer_watch_enable_bit_i;

    always_comb
    begin
        if (sts[2]) // [R12]
            wait_len = WAIT_W'(1) << PMT_WAIT_MAX_LOG2;
        else
            wait_len = WAIT_W'(1) << (PMT_WAIT_BASE_LOG2 + int'(sts[1:0]));
    end

    always_comb
    begin
        mode_d = mode_q;
        wait_d = wait_q;
        case (mode_q)
            PMT_ACT_HIGH, PMT_ACT_MED:
            begin
                if (sleep_exec_i)
                begin
                    if (direct_en && stby_sel && tw && low_spd)
                        mode_d = PMT_SUBACT; // [R7]
                    else if (direct_en && !stby_sel && !low_spd && med_spd
                             && mode_q == PMT_ACT_HIGH)
                        mode_d = PMT_ACT_MED; // [R6]
                    else if (direct_en && !stby_sel && !low_spd && !med_spd
                             && mode_q == PMT_ACT_MED)
                        mode_d = PMT_ACT_HIGH; // [R8]
                    else if (!stby_sel)
                        mode_d = PMT_SLEEP; // [R1] [R5]
                    else if (tw)
                        mode_d = PMT_WATCH; // [R3] [R5]
                    else
                    begin
                        mode_d = PMT_STANDBY; // [R3]
                        wait_d = wait_len;
                    end
                end
            end
            PMT_SUBACT:
            begin
                if (sleep_exec_i)
                begin
                    if (direct_en && stby_sel && tw && !low_spd)
                        mode_d = med_spd ? PMT_ACT_MED
                                         : PMT_ACT_HIGH; // [R9] [R10]
                    else if (!stby_sel)
                        mode_d = PMT_SUBSLEEP; // [R2] [R5]
                    else
                        mode_d = PMT_WATCH; // [R4] [R5]
                end
            end
            PMT_SLEEP:
            begin
                if (wake_i)
                    mode_d = med_spd ? PMT_ACT_MED : PMT_ACT_HIGH;
            end
            PMT_SUBSLEEP:
            begin
                if (wake_i)
                    mode_d = PMT_SUBACT;
            end
            PMT_STANDBY, PMT_WATCH:
            begin
                if (wait_q != '0)
                begin
                    wait_d = wait_q - WAIT_W'(1);
                    if (wait_q == WAIT_W'(1))
                        mode_d = PMT_ACT_HIGH;
                end
                else if (wake_i)
                begin
                    if (mode_q == PMT_WATCH && low_spd)
                        mode_d = PMT_SUBACT;
                    else
                        wait_d = wait_len; // oscillator settling
                end
            end
            default: mode_d = PMT_ACT_HIGH;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= PMT_ACT_HIGH;
            wait_q <= '0;
        end
        else if (ce_i)
        begin
            mode_q <= mode_d;
            wait_q <= wait_d;
        end
    end

    // ----------------------------------------
    // clock dividers and outputs
    // ----------------------------------------
    pmt_div_if med_if ();
    pmt_div_if nse_if ();

    assign med_if.run   = (mode_q == PMT_ACT_MED);
    assign med_if.shift = {1'b0, ssc_q[PMT_MA_LSB +: 2]} + 3'd2; // [R13]
    assign nse_if.run   = 1'b1;
    assign nse_if.shift = tsc_q[PMT_NOISE_SEL_BIT] ? 3'd0 : 3'd2; // [R11]

    pmt_divider #(.CNT_W(8)) u_med
    (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .dif     (med_if)
    );

    pmt_divider #(.CNT_W(8)) u_nse
    (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .dif     (nse_if)
    );

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_o                    <= 3'(PMT_ACT_HIGH);
            cpu_stopped_o             <= 1'b0;
            cpu_on_subclock_o         <= 1'b0;
            cpu_clk_en_o              <= 1'b1;
            noise_sample_o            <= 1'b0;
            subactive_clock_divider_o <= 2'b00;
        end
        else if (ce_i)
        begin
            mode_o            <= mode_d;
            cpu_stopped_o     <= !(mode_d == PMT_ACT_HIGH
                                   || mode_d == PMT_ACT_MED
                                   || mode_d == PMT_SUBACT);
            cpu_on_subclock_o <= (mode_d == PMT_SUBACT);
            cpu_clk_en_o      <= (mode_d == PMT_ACT_HIGH)
                              || (mode_d == PMT_SUBACT)
                              || (mode_d == PMT_ACT_MED && med_if.tick);
            noise_sample_o    <= nse_if.tick;
            subactive_clock_divider_o <= tsc_q[PMT_SA_LSB +: 2];
        end
    end
endmodule
`default_nettype wire

// >>> verif/pmt_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// mode checker
// ----
module pmt_sva
    import pmt_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        sleep_exec_i,
    input wire logic        timer_watch_enable_bit_i,
    input wire logic [2:0]  mode_o,
    input wire logic        cpu_stopped_o
);
    logic [7:0] ssc_q;
    logic [7:0] ssc_d;
    logic [7:0] tsc_q;
    logic [7:0] tsc_d;
    logic       wr;
    logic       go;
    logic       act;

    // shadow of the control registers
    always_comb
    begin
        wr    = psel_i & penable_i & !pready_o & pwrite_i & ce_i;
        ssc_d = (wr && paddr_i == PMT_OFS_SSC) ? pwdata_i[7:0] : ssc_q;
        tsc_d = (wr && paddr_i == PMT_OFS_TSC) ? pwdata_i[7:0] : tsc_q;
        go    = sleep_exec_i & ce_i;
        act   = mode_o == PMT_ACT_HIGH || mode_o == PMT_ACT_MED;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ssc_q <= PMT_SSC_RST;
            tsc_q <= PMT_TSC_RST;
        end
        else
        begin
            ssc_q <= ssc_d;
            tsc_q <= tsc_d;
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_sleep_entry: assert property (
        go && act && !tsc_q[3] && !ssc_q[7] |=> mode_o == PMT_SLEEP)
        else $error("sleep not entered");
    a_standby_entry: assert property (
        go && act && !tsc_q[3] && ssc_q[7]
        |=> mode_o inside {PMT_STANDBY, PMT_WATCH})
        else $error("standby or watch not entered");
    a_sub_down: assert property (
        go && mode_o == PMT_SUBACT && !tsc_q[3]
        |=> mode_o == ($past(ssc_q[7]) ? PMT_WATCH : PMT_SUBSLEEP))
        else $error("subactive power down wrong");
    a_only_down: assert property (
        go && mode_o <= PMT_SUBACT && !tsc_q[3] |=> cpu_stopped_o)
        else $error("cpu kept running");
    a_high_to_med: assert property (
        go && mode_o == PMT_ACT_HIGH && tsc_q[3] && !ssc_q[7] && tsc_q[2]
        && !ssc_q[3] |=> mode_o == PMT_ACT_MED)
        else $error("no direct move to medium");
    a_to_subact: assert property (
        go && act && tsc_q[3] && ssc_q[7] && timer_watch_enable_bit_i
        && ssc_q[3] |=> mode_o == PMT_SUBACT)
        else $error("no direct move to subactive");
    a_med_to_high: assert property (
        go && mode_o == PMT_ACT_MED && tsc_q[3] && !ssc_q[7] && !tsc_q[2]
        && !ssc_q[3] |=> mode_o == PMT_ACT_HIGH)
        else $error("no direct move to high");
    a_sub_to_act: assert property (
        go && mode_o == PMT_SUBACT && tsc_q[3] && ssc_q[7] && !ssc_q[3]
        && timer_watch_enable_bit_i |=> mode_o == {2'b00, $past(tsc_q[2])})
        else $error("subactive direct move wrong");
    a_apb_answer: assert property (
        psel_i && penable_i && !pready_o && ce_i |=> pready_o ##1 !pready_o)
        else $error("apb answer wrong");
endmodule

bind pmt_top pmt_sva u_sva (.mclk_i, .rst_n_i, .ce_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .sleep_exec_i,
    .timer_watch_enable_bit_i, .mode_o, .cpu_stopped_o);
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// bench
// ----
module testbench;
    import pmt_pkg::*;
    logic        mclk_i = 0;
    logic        rst_n_i = 0;
    logic        ce_i = 1;
    logic        psel_i = 0;
    logic        penable_i = 0;
    logic        pwrite_i = 0;
    logic [7:0]  paddr_i = 0;
    logic [31:0] pwdata_i = 0;
    logic        sleep_exec_i = 0;
    logic        timer_watch_enable_bit_i = 0;
    logic        wake_i = 0;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [2:0]  mode_o;
    logic        cpu_stopped_o;
    logic        cpu_on_subclock_o;
    logic        cpu_clk_en_o;
    logic        noise_sample_o;
    logic [1:0]  subactive_clock_divider_o;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          m = 0;
    int          e;
    int          n;
    int          w;
    bit          done = 0;
    logic [31:0] r = 32'h2d60;
    logic [7:0]  ssc;
    logic [7:0]  tsc;
    // ssc, tsc, timer bit
    logic [19:0] st[$] = '{20'h0_0000, 20'h0_00c0, 20'h0_0040, 20'h0_0080,
        20'h8_8081, 20'h8_8001, 20'h8_0081, 20'h8_8081, 20'h8_00c1,
        20'h8_8081, 20'h8_0081, 20'h9_0001, 20'h8_0000, 20'h8_8081,
        20'h0_8000};

    pmt_top dut
    (
        .mclk_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .sleep_exec_i,
        .timer_watch_enable_bit_i, .wake_i, .mode_o, .cpu_stopped_o,
        .cpu_on_subclock_o, .cpu_clk_en_o, .noise_sample_o,
        .subactive_clock_divider_o
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected mode after a sleep instruction
    function automatic int mdl(input int c, input logic t);
        logic s;
        logic l;
        logic d;
        s = ssc[7];
        l = ssc[3];
        d = tsc[3];
        if (d && c == 0 && !s && tsc[2] && !l)
            return 1;
        if (d && c < 2 && s && t && l)
            return 2;
        if (d && c == 1 && !s && !tsc[2] && !l)
            return 0;
        if (d && c == 2 && s && t && !l)
            return tsc[2];
        if (c == 2)
            return s ? 6 : 4;
        return !s ? 3 : t ? 6 : 5;
    endfunction

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task hang;
        n_mismatch++;
        tally_and_finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] x, input logic err);
        int i;
        i = 0;
        psel_i    <= 1;
        penable_i <= 0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge mclk_i);
        penable_i <= 1;
        do
        begin
            @(posedge mclk_i);
            i++;
        end
        while (pready_o !== 1 && i < 50);
        if (i == 50)
            hang;
        if (!wr)
            check(prdata_o, x);
        check(pslverr_o, err);
        psel_i    <= 0;
        penable_i <= 0;
        @(posedge mclk_i);
    endtask

    task wait_mode(input int x, output int k);
        k = 0;
        while (mode_o !== x[2:0] && k < 20000)
        begin
            @(posedge mclk_i);
            k++;
        end
        if (k == 20000)
            hang;
    endtask

    // cycles between two pulses of a strobe
    task gap(input bit s, input int x);
        int k;
        k = 0;
        while ((s ? noise_sample_o : cpu_clk_en_o) !== 1 && k < 300)
        begin
            @(posedge mclk_i);
            k++;
        end
        if (k == 300)
            hang;
        k = 0;
        do
        begin
            @(posedge mclk_i);
            k++;
        end
        while ((s ? noise_sample_o : cpu_clk_en_o) !== 1 && k < 300);
        check(k, x);
    endtask

    task step(input logic [19:0] v);
        ssc = v[19:12];
        tsc = v[11:4];
        apb(1, PMT_OFS_SSC, ssc, 0, 0);
        apb(1, PMT_OFS_TSC, tsc, 0, 0);
        e = mdl(m, v[0]);
        timer_watch_enable_bit_i <= v[0];
        sleep_exec_i <= 1;
        @(posedge mclk_i);
        sleep_exec_i <= 0;
        @(posedge mclk_i);
        check(mode_o, e);
        check(cpu_stopped_o, e > 2);
        check(cpu_on_subclock_o, e == 2);
        if (e != 1)
            check(cpu_clk_en_o, e == 0 || e == 2);
        m = e;
        w = 1 << (ssc[6] ? PMT_WAIT_MAX_LOG2 : PMT_WAIT_BASE_LOG2 + ssc[5:4]);
        if (m > 2)
        begin
            wake_i <= (m != 5);
            e = m == 3 ? tsc[2] : (m == 6 && ssc[3] || m == 4) ? 2 : 0;
            wait_mode(e, n);
            wake_i <= 0;
            if (m == 5 || m == 6 && e == 0)
                check(n >= w - 4 && n <= w + 4, 1);
            m = e;
        end
        if (m == 1 && !done)
        begin
            done = 1;
            for (int k = 0; k < 4; k++)
            begin
                apb(1, PMT_OFS_SSC, k, 0, 0);
                gap(0, PMT_MED_DIV_BASE << k);
            end
        end
        apb(0, PMT_OFS_MODE, 0, m, 0);
    endtask

    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end

    initial
    begin
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1;
        repeat (3) @(posedge mclk_i);
        apb(0, PMT_OFS_SSC, 0, PMT_SSC_RST, 0);
        apb(0, PMT_OFS_TSC, 0, PMT_TSC_RST, 0);
        apb(1, 8'h10, 0, 0, 1);
        apb(0, 8'h10, 0, 0, 1);
        repeat (4)
        begin
            r = lfsr(r);
            apb(1, PMT_OFS_SSC, r, 0, 0);
            apb(1, PMT_OFS_TSC, r, 0, 0);
            apb(0, PMT_OFS_SSC, 0,
                r[7:0] & PMT_SSC_WMSK | PMT_SSC_RST & ~PMT_SSC_WMSK, 0);
            apb(0, PMT_OFS_TSC, 0,
                r[7:0] & PMT_TSC_WMSK | PMT_TSC_RST & ~PMT_TSC_WMSK, 0);
            check(subactive_clock_divider_o, r[1:0]);
        end
        $display("register test done");
        apb(1, PMT_OFS_TSC, 0, 0, 0);
        gap(1, PMT_NOISE_DIV_SLOW);
        apb(1, PMT_OFS_TSC, 8'h10, 0, 0);
        gap(1, PMT_NOISE_DIV_FAST);
        $display("noise rate test done");
        // frozen block ignores sleep and stops its dividers
        ce_i         <= 0;
        sleep_exec_i <= 1;
        @(posedge mclk_i);
        sleep_exec_i <= 0;
        n = noise_sample_o;
        repeat (8)
        begin
            @(posedge mclk_i);
            check(noise_sample_o, n);
        end
        check(mode_o, 0);
        ce_i <= 1;
        @(posedge mclk_i);
        $display("clock enable test done");
        foreach (st[i])
            step(st[i]);
        apb(0, PMT_OFS_WAIT, 0, 0, 0);
        $display("mode sequence done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
